// *** hw/tsw_switch.sv ***
// Purpose: time-slot interchange switch top with host port
// Assumes: serial clock sampled as an ordinary input
// Notes: memories are not cleared by reset, only counters and registers
`timescale 1ns/1ps
module tsw_switch #(
    parameter int NS = tsw_pkg::NUM_STREAMS,
    parameter int NC = tsw_pkg::MAX_CHANNELS
) (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    input logic ce,
    // host port
    input logic port_select_n,
    input logic access_strobe_n,
    input logic read_not_write,
    input logic [15:0] host_address_bus,
    input logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic host_data_oe,
    output logic transfer_ack,
    output logic transfer_ack_oe,
    // timing pins
    input logic serial_clk,
    input logic frame_sync,
    input logic wide_frame_select,
    input logic frame_eval_or_aux_clock,
    input logic tx_drive_gate,
    // serial streams
    input logic [NS-1:0] serial_in_streams,
    output logic [NS-1:0] serial_out_streams,
    output logic [NS-1:0] serial_out_oe
);
    typedef struct packed {
        logic sclk_prev;
        logic phase;
        logic [2:0] bit_cnt;
        logic [7:0] ch_cnt;
        logic bank;
        logic [NS-1:0][7:0] in_sh;
        logic [NS-1:0][7:0] out_sh;
        logic [NS-1:0] ch_en;
        logic [NS-1:0] tx_oe;
        logic [NS-1:0] strm_dis;
        logic [15:0] ctrl;
        logic [15:0] rdata;
    } tsw_sw_t;
    tsw_sw_t q, d;

    // data memory holds two frames, connection memory one entry per output slot
    logic [7:0] dm_mem [2*NS*NC];
    logic [15:0] cm_mem [NS*NC];

    tsw_pkg::tsw_host_req_t req;
    tsw_pkg::tsw_akind_t wr_kind;
    tsw_pkg::tsw_akind_t rd_kind;
    tsw_pkg::tsw_rate_t rate;
    logic sclk_rise;
    logic bit_tick;
    logic byte_done;
    logic frame_start;
    logic gci_format;
    logic [3:0] eval_offset;
    logic [7:0] ch_last;
    logic [7:0] next_ch;
    logic [7:0] load_ch;
    logic load_bank;
    logic do_load;
    logic drive_ok;
    logic [NS-1:0][7:0] ld_byte;
    logic [NS-1:0] ld_en;
    logic [15:0] cm_rd;
    logic [7:0] dm_rd;

    tsw_cpu_port u_cpu (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .port_select_n(port_select_n),
        .access_strobe_n(access_strobe_n),
        .read_not_write(read_not_write),
        .host_address_bus(host_address_bus),
        .host_data_in(host_data_in),
        .host_data_out(host_data_out),
        .host_data_oe(host_data_oe),
        .transfer_ack(transfer_ack),
        .transfer_ack_oe(transfer_ack_oe),
        .req(req),
        .rdata(q.rdata)
    );

    tsw_frame_align u_align (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .sclk_rise(sclk_rise),
        .frame_sync(frame_sync),
        .wide_frame_select(wide_frame_select),
        .frame_eval_or_aux_clock(frame_eval_or_aux_clock),
        .frame_start(frame_start),
        .gci_format(gci_format),
        .eval_offset(eval_offset)
    );

    // bit timing: two serial clocks per bit except at the top rate
    assign rate = tsw_pkg::tsw_rate_t'(q.ctrl[tsw_pkg::CTRL_RATE_LSB +: 2]);
    assign sclk_rise = serial_clk & ~q.sclk_prev;
    assign bit_tick = sclk_rise & ((rate == tsw_pkg::RATE_16M) | q.phase);
    assign byte_done = bit_tick & (q.bit_cnt == 3'h7);
    // channels per frame: 32 at the lowest rate, doubling each step
    assign ch_last = tsw_pkg::CH_LAST_MAX >> (2'h3 - rate);
    assign next_ch = (q.ch_cnt == ch_last) ? 8'h00 : 8'(q.ch_cnt + 8'h01);

    // the next channel's bytes are fetched as the current one ends
    assign do_load = frame_start | byte_done;
    assign load_ch = frame_start ? 8'h00 : next_ch;
    assign load_bank = frame_start ? ~q.bank : q.bank;

    // per-output-stream slot fetch
    for (genvar g = 0; g < NS; g++) begin : g_ld
        tsw_pkg::tsw_cm_entry_t ent;
        logic fresh;
        logic src_bank;
        assign ent = tsw_pkg::tsw_cm_entry_t'(cm_mem[{6'(g), load_ch}]);
        // a source is fresh once fully received in the frame now running
        assign fresh = ~frame_start & (ent.src_channel < q.ch_cnt);
        // constant delay always reads the last whole frame, keeping frame order
        assign src_bank = (ent.mode == tsw_pkg::CM_CONST || !fresh) ? ~load_bank : load_bank;
        assign ld_byte[g] = (ent.mode == tsw_pkg::CM_PROC) ? ent.src_channel :
            dm_mem[{src_bank, ent.src_stream, ent.src_channel}];
        assign ld_en[g] = (ent.mode != tsw_pkg::CM_TRI);
    end

    // output drivers live only with the gate or the standby bit
    assign drive_ok = tx_drive_gate | q.ctrl[tsw_pkg::CTRL_STANDBY_BIT];

    // host decode, shared function for both directions
    assign wr_kind = tsw_pkg::tsw_decode(req.addr);
    assign rd_kind = tsw_pkg::tsw_decode(req.addr);
    assign cm_rd = cm_mem[req.addr[13:0]];
    assign dm_rd = dm_mem[{~q.bank, req.addr[13:0]}];

    // state update
    always_comb begin
        d = q;
        d.sclk_prev = serial_clk;
        if (sclk_rise) begin
            d.phase = ~q.phase;
        end
        if (bit_tick) begin
            d.bit_cnt = 3'(q.bit_cnt + 3'h1);
            for (int s = 0; s < NS; s++) begin
                d.in_sh[s] = {q.in_sh[s][6:0], serial_in_streams[s]};
                d.out_sh[s] = {q.out_sh[s][6:0], 1'b0};
            end
        end
        if (byte_done) begin
            d.ch_cnt = next_ch;
        end
        if (frame_start) begin
            d.phase = 1'b0;
            d.bit_cnt = 3'h0;
            d.ch_cnt = 8'h00;
            d.bank = ~q.bank;
        end
        if (do_load) begin
            d.out_sh = ld_byte;
            d.ch_en = ld_en;
        end
        for (int s = 0; s < NS; s++) begin
            d.tx_oe[s] = drive_ok & q.ch_en[s] & ~q.strm_dis[s];
        end
        // host writes
        if (req.wr) begin
            case (wr_kind)
                tsw_pkg::AK_CTRL: d.ctrl = req.wdata;
                tsw_pkg::AK_STRM: d.strm_dis[req.addr[5:0]] = req.wdata[0];
                default: d.ctrl = q.ctrl;
            endcase
        end
        // host reads answer one cycle later
        if (req.rd) begin
            case (rd_kind)
                tsw_pkg::AK_CTRL: d.rdata = q.ctrl;
                tsw_pkg::AK_STAT: d.rdata = {8'h00, eval_offset, 1'b0, gci_format, q.bank, 1'b0};
                tsw_pkg::AK_STRM: d.rdata = {15'h0000, q.strm_dis[req.addr[5:0]]};
                tsw_pkg::AK_CM: d.rdata = cm_rd;
                tsw_pkg::AK_DM: d.rdata = {8'h00, dm_rd};
                default: d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
            q.ctrl <= tsw_pkg::CTRL_RESET;
        end else if (ce) begin
            q <= d;
        end
    end

    // memories: data memory takes one byte per stream as each channel completes, connection memory takes host writes
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (byte_done) begin
                for (int s = 0; s < NS; s++) begin
                    dm_mem[{q.bank, 6'(s), q.ch_cnt}] <= {q.in_sh[s][6:0], serial_in_streams[s]};
                end
            end
            if (req.wr && wr_kind == tsw_pkg::AK_CM) begin
                cm_mem[req.addr[13:0]] <= req.wdata;
            end
        end
    end

    // serial pins come straight from flops
    for (genvar g = 0; g < NS; g++) begin : g_tx
        assign serial_out_streams[g] = q.out_sh[g][7];
        assign serial_out_oe[g] = q.tx_oe[g];
    end
endmodule

// *** hw/tsw_pkg.sv ***
// Purpose: shared constants and types of the time-slot switch
// Assumes: one clock clk_sys, synchronous active-low reset rst_n
// Notes: host map, connection entry layout and rates live here
// Overview of operation
// - capacity 32 channels per stream, doubling per rate
// - 64 in, 64 out streams, per-stream disable
// - switch bytes, keep frame or minimise delay
// - per-channel variable or constant delay mode
// - sixteen-bit address reaches all memories
// - sixteen-bit two-way host data bus
// - control register picks serial clock rate
// - port select high ignores host signals
// - access and data drivers only with strobe, select; the acknowledge stays driven one cycle after they drop
// - acknowledge driven high, then released
// - shared pin: frame measure or aux clock
// - standard mode auto-detects frame pulse polarity
// - wide mode takes negative pulse on aux clock
// - gate low, standby low: outputs high impedance
// - gate high enables, per-channel tristate remains
// - reset clears state, floats outputs, data bus
// - wide select chooses frame alignment interface
// - read/write input sets data bus direction
// - frame pulse restarts channel addressing
package tsw_pkg;
    localparam int NUM_STREAMS = 64;
    localparam int MAX_CHANNELS = 256;
    localparam int CH_BITS = 8;
    localparam int ST_BITS = 6;
    // host address map
    localparam logic [15:0] ADDR_CTRL = 16'h0000;
    localparam logic [15:0] ADDR_STATUS = 16'h0001;
    localparam logic [9:0] ADDR_STRM_PAGE = 10'h004;
    localparam logic [1:0] ADDR_DM_PAGE = 2'h1;
    localparam int ADDR_CM_BIT = 15;
    // control register
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_STANDBY_BIT = 2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [7:0] CH_LAST_MAX = 8'hff;
    // timing
    localparam logic [4:0] FMT_IDLE_CLKS = 5'h10;
    localparam logic [3:0] EVAL_MAX = 4'hf;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_MIN_NS = 20;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M} tsw_rate_t;
    typedef enum logic [1:0] {CM_VAR, CM_CONST, CM_PROC, CM_TRI} tsw_cm_mode_t;
    typedef struct packed {
        tsw_cm_mode_t mode;
        logic [5:0] src_stream;
        logic [7:0] src_channel;
    } tsw_cm_entry_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } tsw_host_req_t;
    typedef enum logic [2:0] {AK_NONE, AK_CTRL, AK_STAT, AK_STRM, AK_CM, AK_DM} tsw_akind_t;
    // host address decode, shared by the read and write paths
    function automatic tsw_akind_t tsw_decode(input logic [15:0] a);
        tsw_akind_t k;
        k = AK_NONE;
        if (a[ADDR_CM_BIT]) begin
            k = AK_CM;
        end else if (a[15:14] == ADDR_DM_PAGE) begin
            k = AK_DM;
        end else if (a[15:6] == ADDR_STRM_PAGE) begin
            k = AK_STRM;
        end else if (a == ADDR_CTRL) begin
            k = AK_CTRL;
        end else if (a == ADDR_STATUS) begin
            k = AK_STAT;
        end
        return k;
    endfunction
endpackage

// *** hw/tsw_cpu_port.sv ***
// Purpose: host strobe port to one-cycle internal access
// Assumes: host pins synchronous to clk_sys
// Notes: read data is latched and held until the strobe drops
`timescale 1ns/1ps
module tsw_cpu_port (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    input logic ce,
    // host pins
    input logic port_select_n,
    input logic access_strobe_n,
    input logic read_not_write,
    input logic [15:0] host_address_bus,
    input logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic host_data_oe,
    output logic transfer_ack,
    output logic transfer_ack_oe,
    // internal access
    output tsw_pkg::tsw_host_req_t req,
    input logic [15:0] rdata
);
    typedef enum {CP_IDLE, CP_ISSUE, CP_LATCH, CP_HOLD, CP_RELEASE} tsw_cp_state_t;
    typedef struct packed {
        tsw_cp_state_t st;
        logic is_rd;
        tsw_pkg::tsw_host_req_t req;
        logic [15:0] dout;
    } tsw_cp_t;
    tsw_cp_t q, d;
    logic sel;

    assign sel = ~port_select_n & ~access_strobe_n;

    // access sequencer
    always_comb begin
        d = q;
        d.req.wr = 1'b0;
        d.req.rd = 1'b0;
        case (q.st)
            CP_IDLE: begin
                if (sel) begin
                    d.req.addr = host_address_bus;
                    d.req.wdata = host_data_in;
                    d.req.rd = read_not_write;
                    d.req.wr = ~read_not_write;
                    // the request bit lasts one cycle, the direction must last the access
                    d.is_rd = read_not_write;
                    d.st = CP_ISSUE;
                end
            end
            CP_ISSUE: d.st = CP_LATCH;
            CP_LATCH: begin
                d.dout = rdata;
                d.st = sel ? CP_HOLD : CP_RELEASE;
            end
            CP_HOLD: if (!sel) d.st = CP_RELEASE;
            CP_RELEASE: d.st = CP_IDLE;
            default: d.st = CP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign req = q.req;
    assign host_data_out = q.dout;
    // drive only while selected, so a dropped strobe frees the bus at once
    assign host_data_oe = (q.st == CP_HOLD) & q.is_rd & sel;
    assign transfer_ack = (q.st == CP_RELEASE);
    assign transfer_ack_oe = (q.st == CP_HOLD) | (q.st == CP_RELEASE);
endmodule

// *** hw/tsw_frame_align.sv ***
// Purpose: frame start detection and frame offset measurement
// Assumes: serial clock edges arrive as a one-cycle pulse
// Notes: polarity is learnt from the idle level of the frame pin
`timescale 1ns/1ps
module tsw_frame_align (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    input logic ce,
    // timing inputs
    input logic sclk_rise,
    input logic frame_sync,
    input logic wide_frame_select,
    input logic frame_eval_or_aux_clock,
    // results
    output logic frame_start,
    output logic gci_format,
    output logic [3:0] eval_offset
);
    typedef struct packed {
        logic fs_prev;
        logic pin_prev;
        logic [4:0] idle_cnt;
        logic known;
        logic gci;
        logic eval_run;
        logic [3:0] eval_cnt;
        logic [3:0] eval_off;
        logic start;
    } tsw_fa_t;
    tsw_fa_t q, d;
    logic pin_rise;
    logic evt;

    assign pin_rise = frame_eval_or_aux_clock & ~q.pin_prev;
    assign evt = wide_frame_select ? pin_rise : sclk_rise;

    always_comb begin
        d = q;
        d.pin_prev = frame_eval_or_aux_clock;
        d.start = 1'b0;
        if (evt) begin
            d.fs_prev = frame_sync;
            if (wide_frame_select) begin
                d.start = q.fs_prev & ~frame_sync;
            end else begin
                // the long idle level tells the pulse polarity
                if (frame_sync == q.fs_prev) begin
                    if (q.idle_cnt != tsw_pkg::FMT_IDLE_CLKS) begin
                        d.idle_cnt = 5'(q.idle_cnt + 5'h01);
                    end else begin
                        d.known = 1'b1;
                        d.gci = ~frame_sync;
                    end
                end else begin
                    d.idle_cnt = 5'h00;
                end
                if (q.known) begin
                    d.start = q.gci ? (frame_sync & ~q.fs_prev) : (~frame_sync & q.fs_prev);
                end
            end
        end
        // offset measurement, only where the pin is not a clock
        if (!wide_frame_select) begin
            if (q.start) begin
                d.eval_run = 1'b1;
                d.eval_cnt = 4'h0;
            end else if (q.eval_run) begin
                if (pin_rise || q.eval_cnt == tsw_pkg::EVAL_MAX) begin
                    d.eval_off = q.eval_cnt;
                    d.eval_run = 1'b0;
                end else if (sclk_rise) begin
                    d.eval_cnt = 4'(q.eval_cnt + 4'h1);
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign frame_start = q.start;
    assign gci_format = q.gci;
    assign eval_offset = q.eval_off;
endmodule

// *** bench/tsw_switch_properties.sv ***
// Purpose: port-level checks on the switch top
// Assumes: bound into tsw_switch, one clk_sys domain
// Notes: standby has no pin, so it is shadowed from host writes
`timescale 1ns/1ps
module tsw_switch_chk #(
    parameter int NS = 64
) (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    // host port
    input logic port_select_n,
    input logic access_strobe_n,
    input logic read_not_write,
    input logic [15:0] host_address_bus,
    input logic [15:0] host_data_in,
    input logic [15:0] host_data_out,
    input logic host_data_oe,
    input logic transfer_ack,
    input logic transfer_ack_oe,
    // serial side
    input logic tx_drive_gate,
    input logic [NS-1:0] serial_out_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic stby_q;
    logic sel_w;
    logic hold_w;
    // shadow leads the real bit by a cycle; the repeat below absorbs it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stby_q <= 1'b0;
        end else if (sel_w && !read_not_write && host_address_bus == tsw_pkg::ADDR_CTRL) begin
            stby_q <= host_data_in[tsw_pkg::CTRL_STANDBY_BIT];
        end
    end
    // both selects low, and the waiting phase of the acknowledge
    assign sel_w = !port_select_n && !access_strobe_n;
    assign hold_w = transfer_ack_oe && !transfer_ack;
    property p_ack_lat;
        $fell(access_strobe_n) && !port_select_n && !transfer_ack_oe |-> ##3 hold_w;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    property p_ack_hold;
        hold_w && sel_w |=> hold_w;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack hold lost");
    property p_release;
        hold_w && !sel_w |=> transfer_ack_oe && transfer_ack ##1 !transfer_ack_oe;
    endproperty
    a_release: assert property (p_release) else $error("bad ack release");
    property p_data_oe;
        host_data_oe |-> sel_w && read_not_write && hold_w;
    endproperty
    a_data_oe: assert property (p_data_oe) else $error("data driven outside read");
    property p_rdata;
        host_data_oe && $past(host_data_oe) |-> $stable(host_data_out);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
    property p_idle;
        port_select_n [*6] |-> !transfer_ack_oe;
    endproperty
    a_idle: assert property (p_idle) else $error("ack while deselected");
    property p_gate_off;
        (!tx_drive_gate && !stby_q) [*4] |-> serial_out_oe == '0;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("tx driven, gate off");
    property p_rst;
        disable iff (1'b0) !rst_n |=> serial_out_oe == '0 && !host_data_oe && !transfer_ack_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("pins driven in reset");
endmodule

bind tsw_switch tsw_switch_chk #(.NS(NS)) u_chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .port_select_n(port_select_n),
    .access_strobe_n(access_strobe_n),
    .read_not_write(read_not_write),
    .host_address_bus(host_address_bus),
    .host_data_in(host_data_in),
    .host_data_out(host_data_out),
    .host_data_oe(host_data_oe),
    .transfer_ack(transfer_ack),
    .transfer_ack_oe(transfer_ack_oe),
    .tx_drive_gate(tx_drive_gate),
    .serial_out_oe(serial_out_oe)
);

// *** bench/tsw_tdm_far.sv ***
// Purpose: stream-side partner: serial clock, frame pulse, input data
// Assumes: serial clock is a quarter of clk_sys, free running
// Notes: 512 serial clocks per frame fit the lowest rate, 32 channels
`timescale 1ns/1ps
module tsw_tdm_far (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    // mode
    input logic wide_frame_select,
    // stream timing
    output logic serial_clk,
    output logic frame_sync,
    output logic frame_eval_or_aux_clock,
    // data
    output logic [63:0] serial_in_streams
);
    logic [10:0] cnt_q;
    // [1:0] phase of serial clock, [10:2] serial clock within frame
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= 11'h000;
        end else begin
            cnt_q <= cnt_q + 11'h001;
        end
    end
    // clock rate matches the lowest rate programmed after reset
    assign serial_clk = cnt_q[1];
    // idle high, low for one serial clock at the frame edge
    assign frame_sync = (cnt_q[10:2] != 9'h000);
    // wide mode wants a clock on the shared pin; the serial clock serves
    assign frame_eval_or_aux_clock = wide_frame_select ? cnt_q[1] :
        ((cnt_q[10:2] >= 9'h003) && (cnt_q[10:2] < 9'h100));
    assign serial_in_streams = {64{cnt_q[5]}};
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for the switch top
// Assumes: host pins driven just after rising clk_sys
// Notes: stream 0 output enables are judged alone except in reset and the first gate-off check; others are unset
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sel_n = 1'b1;
    logic stb_n = 1'b1;
    logic rnw = 1'b1;
    logic gate = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] dout;
    logic [15:0] q;
    logic wfs = 1'b0;
    logic [7:0] b8;
    logic [15:0] w16;
    logic hit, b, q_oe;
    logic data_oe, ack, ack_oe, sclk, fsync, feval;
    logic [63:0] rx, tx, tx_oe;
    int fails = 0;
    int num_checks = 0;
    // free clock, 100 ns period
    always #50 clk_sys = ~clk_sys;
    tsw_tdm_far far (.clk_sys(clk_sys), .rst_n(rst_n), .wide_frame_select(wfs),
        .serial_clk(sclk), .frame_sync(fsync), .frame_eval_or_aux_clock(feval),
        .serial_in_streams(rx));
    tsw_switch DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .port_select_n(sel_n),
        .access_strobe_n(stb_n), .read_not_write(rnw), .host_address_bus(addr),
        .host_data_in(wdata), .host_data_out(dout), .host_data_oe(data_oe),
        .transfer_ack(ack), .transfer_ack_oe(ack_oe), .serial_clk(sclk),
        .frame_sync(fsync), .wide_frame_select(wfs), .frame_eval_or_aux_clock(feval),
        .tx_drive_gate(gate), .serial_in_streams(rx), .serial_out_streams(tx),
        .serial_out_oe(tx_oe));
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hung(input int n);
        if (n >= 20) begin
            fails++;
            close_out();
        end
    endtask
    // one strobed access; select and strobe held until the ack is seen low
    task automatic xfer(input logic rw, input logic [15:0] a, input logic [15:0] d);
        int n;
        @(posedge clk_sys);
        sel_n <= 1'b0;
        stb_n <= 1'b0;
        rnw <= rw;
        addr <= a;
        wdata <= d;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (!(ack_oe === 1'b1 && ack === 1'b0) && n < 20);
        hung(n);
        q = dout;
        q_oe = data_oe;
        sel_n <= 1'b1;
        stb_n <= 1'b1;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (ack_oe !== 1'b0 && n < 20);
        hung(n);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        xfer(1'b0, a, d);
        chk("wr_oe", 16'h0000, {15'h0, q_oe});
    endtask
    task automatic rd(input string nm, input logic [15:0] a, input logic [15:0] e);
        xfer(1'b1, a, 16'h0000);
        chk(nm, e, q);
        chk("rd_oe", 16'h0001, {15'h0, q_oe});
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // park mid-frame, far from any frame start
    task automatic to_mid();
        int n;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (far.cnt_q !== 11'h400 && n < 2100);
        if (n >= 2100) begin
            fails++;
            close_out();
        end
    endtask
    // main sequence
    initial begin
        wait_cyc(20);
        chk("rst_float", 16'h0000, {13'h0, |tx_oe, data_oe, ack_oe});
        rst_n <= 1'b1;
        rd("ctrl_rst", tsw_pkg::ADDR_CTRL, tsw_pkg::CTRL_RESET);
        for (int r = 0; r < 4; r++) begin
            wr(16'h0000, 16'hc3f8 | 16'(r));
            rd("ctrl_rate", 16'h0000, 16'hc3f8 | 16'(r));
        end
        wr(16'h0000, 16'h0000);
        // strobe alone, select high: nothing may happen
        stb_n <= 1'b0;
        rnw <= 1'b0;
        wdata <= 16'h0003;
        wait_cyc(6);
        chk("ack_idle", 16'h0000, {15'h0, ack_oe});
        stb_n <= 1'b1;
        rd("ctrl_kept", 16'h0000, 16'h0000);
        wr(16'h0200, 16'hffff);
        rd("unmapped", 16'h0200, 16'h0000);
        $display("test host done");
        wait_cyc(4200);
        xfer(1'b1, 16'h0001, 16'h0000);
        chk("gci", 16'h0000, {15'h0, q[2]});
        chk("gate_off", 16'h0000, {15'h0, |tx_oe});
        $display("test frame done");
        // processor mode on every channel of stream 0
        for (int c = 0; c < 32; c++) begin
            wr(16'h8000 | 16'(c), 16'h805a);
        end
        gate <= 1'b1;
        wait_cyc(2100);
        chk("gate_on", 16'h0001, {15'h0, tx_oe[0]});
        // eight bit periods of stream 0; bit phase unknown, so any rotation will do
        to_mid();
        for (int i = 0; i < 8; i++) begin
            wait_cyc(8);
            b8 = {b8[6:0], tx[0]};
        end
        w16 = {b8, b8};
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (w16[i +: 8] == 8'h5a) begin
                hit = 1'b1;
            end
        end
        chk("proc_byte", 16'h0001, {15'h0, hit});
        wr(16'h0100, 16'h0001);
        wait_cyc(4);
        chk("strm_off", 16'h0000, {15'h0, tx_oe[0]});
        wr(16'h0100, 16'h0000);
        gate <= 1'b0;
        wr(16'h0000, 16'h0004);
        wait_cyc(4);
        chk("standby", 16'h0001, {15'h0, tx_oe[0]});
        wr(16'h0000, 16'h0000);
        wait_cyc(4);
        chk("gate_off2", 16'h0000, {15'h0, tx_oe[0]});
        gate <= 1'b1;
        for (int c = 0; c < 32; c++) begin
            wr(16'h8000 | 16'(c), 16'hc000);
        end
        wait_cyc(2100);
        chk("chan_tri", 16'h0000, {15'h0, tx_oe[0]});
        $display("test gate done");
        // one frame start per frame flips the bank, in both alignment modes
        for (int w = 0; w < 2; w++) begin
            wfs <= 1'(w);
            to_mid();
            to_mid();
            xfer(1'b1, 16'h0001, 16'h0000);
            b = q[1];
            to_mid();
            xfer(1'b1, 16'h0001, 16'h0000);
            chk("frame_bank", {15'h0, ~b}, {15'h0, q[1]});
        end
        $display("test wide done");
        // second reset in mid-run with outputs enabled
        wr(16'h0000, 16'h0005);
        rst_n <= 1'b0;
        wait_cyc(2);
        chk("rst2_float", 16'h0000, {13'h0, |tx_oe, data_oe, ack_oe});
        rst_n <= 1'b1;
        rd("ctrl_rst2", 16'h0000, 16'h0000);
        $display("test reset done");
        close_out();
    end
endmodule
